//--- rtl/sensor_cfg_pkg.sv
// shared constants, types and helpers for the sensor configuration bank
package sensor_cfg_pkg;

  // ==========================================================================
  // register map
  localparam int unsigned DATA_W = 12;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned WORD_W = 16;
  localparam logic [3:0] OFS_SEQUENCER_CONTROL = 4'h0;
  localparam logic [3:0] OFS_COLUMN_ORIGIN = 4'h1;
  localparam logic [3:0] OFS_ROW_ORIGIN = 4'h2;
  localparam logic [3:0] OFS_KERNEL_COUNT = 4'h3;
  localparam logic [3:0] OFS_RESET_PULSE_SPAN = 4'h4;
  localparam logic [3:0] OFS_SECOND_SLOPE_POSITION = 4'h5;
  localparam logic [3:0] OFS_THIRD_SLOPE_POSITION = 4'h6;
  localparam logic [3:0] OFS_TRANSFER_POSITION = 4'h7;
  localparam logic [3:0] OFS_CALIBRATION_LEVEL_DAC = 4'h8;
  localparam logic [3:0] OFS_DARK_LEVEL_DAC = 4'h9;
  localparam logic [3:0] OFS_SHIFT_LEVEL_DAC = 4'ha;
  localparam logic [3:0] OFS_CONVERTER_INPUT_ROUTE = 4'hb;
  localparam logic [3:0] OFS_AMPLIFIER_CONFIG = 4'hc;
  localparam logic [3:0] OFS_CONVERTER_TRIM_LOW = 4'hd;
  localparam logic [3:0] OFS_CONVERTER_TRIM_MID = 4'he;
  localparam logic [3:0] OFS_CONVERTER_TRIM_HIGH = 4'hf;

  // ==========================================================================
  // reset values, in offset order
  localparam logic [15:0][11:0] REG_RESET = {
    12'h0db, 12'h6db, 12'hadf, 12'h7b0, 12'h0f0, 12'h055, 12'h06b, 12'h04a,
    12'h1e1, 12'h000, 12'h000, 12'h002, 12'h0a0, 12'h000, 12'h000, 12'h029};
  // implemented bits per register, in offset order
  localparam logic [15:0][11:0] REG_MASK = {
    12'h1ff, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'h0ff, 12'h0ff, 12'h0ff,
    12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'h0ff, 12'h1ff, 12'h0ff, 12'h7ff};

  // ==========================================================================
  // field positions
  localparam int unsigned SEQ_MASTER = 0;
  localparam int unsigned SEQ_SUBSAMPLE = 1;
  localparam int unsigned SEQ_GRAN_LO = 2;
  localparam int unsigned SEQ_AMP_OUT = 4;
  localparam int unsigned SEQ_CALIB_LINE = 5;
  localparam int unsigned SEQ_SECOND_EN = 6;
  localparam int unsigned SEQ_THIRD_EN = 7;
  localparam int unsigned SEQ_COL_FLIP = 8;
  localparam int unsigned SEQ_ROW_FLIP = 9;
  localparam int unsigned SEQ_NDR = 10;
  localparam int unsigned AMP_PRE_ATT = 5;
  localparam int unsigned WORD_ADDR_LO = 12;

  // ==========================================================================
  // timing
  localparam logic [1:0] SEQ_CLK_DIV_LAST = 2'h3;
  localparam logic [7:0] ROW_OVERHEAD_TICKS = 8'h08;
  localparam logic [4:0] FOT_TICKS_LAST = 5'h0f;
  localparam logic [8:0] ROW_LAST = 9'h1df;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {S_IDLE, S_INTEG, S_FOT, S_READ} fsm_t;

  typedef struct packed {
    logic pix_reset;
    logic second_reset;
    logic third_reset;
    logic frame_transfer;
    logic calib_pulse;
  } shutter_t;

  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic [8:0] row;
    logic [7:0] col;
  } readout_t;

  typedef struct packed {
    logic amp_on;
    logic half_gain_on;
  } analog_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe_n;
  } int_pins_t;

  // shutter divider limit from the granularity field
  function automatic logic [3:0] gran_limit(input logic [1:0] gran);
    gran_limit = 4'((4'h1 << gran) - 4'h1);
  endfunction : gran_limit

  // one step up or down, by one or two
  function automatic logic [8:0] step9(input logic [8:0] v, input logic down, input logic two);
    logic [8:0] d;
    d = two ? 9'h002 : 9'h001;
    step9 = down ? 9'(v - d) : 9'(v + d);
  endfunction : step9

endpackage : sensor_cfg_pkg

//--- rtl/image_sensor_sequencer_config.sv
// configuration register bank and frame sequencer of the snapshot sensor
//
// Operation
// - non-destructive mode: reset pixels once, then read several frames without reset
// - sequencer runs on input clock divided by four, like the converters
// - mode 1 sequencer times everything; mode 0 integration follows three pins
// - row subsampling reads one row, skips next; vertical only; off after reset
// - granularity field sets shutter clock division by input clock range
// - amplifier enable 1 turns amplifier on, 0 off; off at reset
// - calibration every line when 1, once per frame when 0
// - second slope enable adds reset at second position; else position ignored
// - third slope enable adds reset at third position; else position ignored
// - column flip 1 reads right to left, 0 left to right
// - eleven-bit sequencer control holds all mode fields, resets to 00000101001
// - readout width counts four-pixel kernels, resets to full line
// - reset pulse length in lines, resets to two
// - frame transfer position in lines, resets to 000111100001
// - input routing has three four-bit fields, resets to 000011110000
// - amplifier register holds gain, unity, attenuation, input, enables, fast bit
// - attenuation bit 0 inserts half gain stage, 1 passes straight
// - calibration word spread over three registers, low part first
// - a fully shifted word loads into addressed register on load strobe
// - frame valid high during frame readout, low during frame overhead
`timescale 1ns/1ps
`default_nettype none

module image_sensor_sequencer_config
  import sensor_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spi_clk,
  input wire logic spi_data,
  input wire logic spi_enable,
  input wire logic seq_rst_n,
  input wire logic [2:0] int_time_in,
  output var sensor_cfg_pkg::int_pins_t int_time,
  output var sensor_cfg_pkg::shutter_t shutter,
  output var sensor_cfg_pkg::readout_t readout,
  output var sensor_cfg_pkg::analog_t analog,
  output logic [15:0][11:0] reg_image
);
  import sensor_cfg_pkg::*;

  typedef struct packed {
    logic [15:0][11:0] regs;
    fsm_t fsm;
    logic [1:0] div;
    logic spi_clk_q;
    logic spi_en_q;
    logic [15:0] shift;
    logic [3:0] gcnt;
    logic [8:0] ltim;
    logic [11:0] line_cnt;
    logic [4:0] fot_cnt;
    logic [7:0] kcnt;
    logic ndr_done;
    logic int1_q;
    shutter_t sh;
    readout_t ro;
    analog_t an;
    int_pins_t ip;
  } state_t;

  state_t st;
  state_t nx;

  // ==========================================================================
  // field views
  logic seq_tick;
  logic master;
  logic subsample;
  logic [1:0] gran;
  logic second_slope_enable;
  logic third_slope_enable;
  logic col_flip;
  logic row_flip;
  logic ndr_on;
  logic calib_line;
  logic shutter_tick;
  logic line_tick;
  logic [11:0] seqc;

  assign seqc = st.regs[OFS_SEQUENCER_CONTROL];
  assign seq_tick = (st.div == SEQ_CLK_DIV_LAST);
  assign master = seqc[SEQ_MASTER];
  assign subsample = seqc[SEQ_SUBSAMPLE];
  assign gran = seqc[SEQ_GRAN_LO +: 2];
  assign calib_line = seqc[SEQ_CALIB_LINE];
  assign second_slope_enable = seqc[SEQ_SECOND_EN];
  assign third_slope_enable = seqc[SEQ_THIRD_EN];
  assign col_flip = seqc[SEQ_COL_FLIP];
  assign row_flip = seqc[SEQ_ROW_FLIP];
  assign ndr_on = seqc[SEQ_NDR];
  assign shutter_tick = seq_tick && (st.gcnt == gran_limit(gran));
  assign line_tick = shutter_tick &&
    (st.ltim == 9'(st.regs[OFS_KERNEL_COUNT][7:0] + ROW_OVERHEAD_TICKS - 8'h01));

  // ==========================================================================
  // next state
  always_comb begin
    nx = st;
    nx.div = 2'(st.div + 2'h1);
    nx.spi_clk_q = spi_clk;
    nx.spi_en_q = spi_enable;
    nx.sh.second_reset = 1'b0;
    nx.sh.third_reset = 1'b0;
    nx.sh.frame_transfer = 1'b0;
    nx.sh.calib_pulse = 1'b0;

    // serial shift and load
    if (spi_clk && !st.spi_clk_q) begin
      nx.shift = {st.shift[14:0], spi_data};
    end
    if (spi_enable && !st.spi_en_q) begin
      nx.regs[st.shift[WORD_ADDR_LO +: ADDR_W]] =
        st.shift[DATA_W-1:0] & REG_MASK[st.shift[WORD_ADDR_LO +: ADDR_W]];
    end

    // shutter divider and line timer
    if (seq_tick) begin
      nx.gcnt = shutter_tick ? 4'h0 : 4'(st.gcnt + 4'h1);
    end
    if (shutter_tick) begin
      nx.ltim = line_tick ? 9'h000 : 9'(st.ltim + 9'h001);
    end

    if (!seq_rst_n) begin
      nx.fsm = S_IDLE;
      nx.sh.pix_reset = 1'b0;
      nx.ro.frame_valid = 1'b0;
      nx.ro.line_valid = 1'b0;
      nx.ndr_done = 1'b0;
      nx.gcnt = 4'h0;
      nx.ltim = 9'h000;
    end else if (seq_tick) begin
      nx.int1_q = int_time_in[0];
      case (st.fsm)
        S_IDLE: begin
          nx.fsm = S_INTEG;
          nx.line_cnt = 12'h000;
          nx.sh.pix_reset = master && !(ndr_on && st.ndr_done);
        end
        S_INTEG: begin
          if (master) begin
            if (line_tick) begin
              nx.line_cnt = 12'(st.line_cnt + 12'h001);
              if (st.line_cnt == 12'(st.regs[OFS_RESET_PULSE_SPAN] - 12'h002)) begin
                nx.sh.pix_reset = 1'b0;
              end
              if (second_slope_enable &&
                  st.line_cnt == 12'(st.regs[OFS_SECOND_SLOPE_POSITION] - 12'h001)) begin
                nx.sh.second_reset = 1'b1;
              end
              if (third_slope_enable &&
                  st.line_cnt == 12'(st.regs[OFS_THIRD_SLOPE_POSITION] - 12'h001)) begin
                nx.sh.third_reset = 1'b1;
              end
              if (st.line_cnt == 12'(st.regs[OFS_TRANSFER_POSITION] - 12'h001)) begin
                nx.sh.frame_transfer = 1'b1;
                nx.sh.pix_reset = 1'b0;
                nx.fsm = S_FOT;
                nx.fot_cnt = 5'h00;
              end
            end
          end else begin
            nx.sh.pix_reset = !int_time_in[0] && !(ndr_on && st.ndr_done);
            nx.sh.second_reset = int_time_in[1];
            nx.sh.third_reset = int_time_in[2];
            if (st.int1_q && !int_time_in[0]) begin
              nx.sh.frame_transfer = 1'b1;
              nx.sh.pix_reset = 1'b0;
              nx.fsm = S_FOT;
              nx.fot_cnt = 5'h00;
            end
          end
        end
        S_FOT: begin
          nx.fot_cnt = 5'(st.fot_cnt + 5'h01);
          if (st.fot_cnt == FOT_TICKS_LAST) begin
            nx.fsm = S_READ;
            nx.ro.frame_valid = 1'b1;
            nx.ro.line_valid = 1'b1;
            nx.ro.row = st.regs[OFS_ROW_ORIGIN][8:0];
            nx.ro.col = 8'({st.regs[OFS_COLUMN_ORIGIN][6:0], 1'b0});
            nx.kcnt = 8'h01;
            nx.sh.calib_pulse = 1'b1;
          end
        end
        S_READ: begin
          if (st.kcnt == st.regs[OFS_KERNEL_COUNT][7:0]) begin
            nx.kcnt = 8'h01;
            nx.ro.col = 8'({st.regs[OFS_COLUMN_ORIGIN][6:0], 1'b0});
            nx.ro.row = step9(st.ro.row, row_flip, subsample);
            nx.sh.calib_pulse = calib_line;
            if ((!row_flip && step9(st.ro.row, 1'b0, subsample) > ROW_LAST) ||
                (row_flip && st.ro.row < (subsample ? 9'h002 : 9'h001))) begin
              nx.fsm = S_IDLE;
              nx.ro.frame_valid = 1'b0;
              nx.ro.line_valid = 1'b0;
              nx.sh.calib_pulse = 1'b0;
              nx.ndr_done = ndr_on;
            end
          end else begin
            nx.kcnt = 8'(st.kcnt + 8'h01);
            nx.ro.col = col_flip ? 8'(st.ro.col - 8'h01) : 8'(st.ro.col + 8'h01);
          end
        end
        default: begin
          nx.fsm = S_IDLE;
        end
      endcase
    end

    // integration pins and analog controls
    nx.ip.oe_n = master ? 3'h0 : 3'h7;
    nx.ip.out = {nx.sh.third_reset, nx.sh.second_reset,
                 (nx.fsm == S_INTEG) && !nx.sh.pix_reset};
    nx.an.amp_on = seqc[SEQ_AMP_OUT];
    nx.an.half_gain_on = !st.regs[OFS_AMPLIFIER_CONFIG][AMP_PRE_ATT];
  end

  // ==========================================================================
  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.regs <= REG_RESET;
      st.fsm <= S_IDLE;
      st.ip.oe_n <= 3'h0;
      st.an.half_gain_on <= 1'b0;
    end else begin
      st <= nx;
    end
  end

  assign int_time = st.ip;
  assign shutter = st.sh;
  assign readout = st.ro;
  assign analog = st.an;
  assign reg_image = st.regs;

  // ==========================================================================
  // assertions
  a_seq_clock_div: assert property (@(posedge core_clk) disable iff (rst)
    seq_tick |=> !seq_tick ##1 !seq_tick ##1 !seq_tick ##1 seq_tick)
    else $error("sequencer tick not every fourth clock");

  a_ndr_no_reset: assert property (@(posedge core_clk) disable iff (rst)
    (seq_rst_n && ndr_on && st.ndr_done && $past(ndr_on)) |-> !$rose(st.sh.pix_reset))
    else $error("pixel reset during non-destructive sequence");

  a_slave_pins_released: assert property (@(posedge core_clk) disable iff (rst)
    !master |=> st.ip.oe_n == 3'h7)
    else $error("integration pins driven in slave mode");

  a_subsample_step: assert property (@(posedge core_clk) disable iff (rst)
    (st.fsm == S_READ && nx.fsm == S_READ && st.ro.row != nx.ro.row && subsample && !row_flip)
      |=> st.ro.row == 9'($past(st.ro.row) + 9'h002))
    else $error("subsampled row step is not two");

  a_second_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (master && !$past(second_slope_enable) && $past(master)) |-> !st.sh.second_reset)
    else $error("second slope reset while disabled");

  a_third_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (master && !$past(third_slope_enable) && $past(master)) |-> !st.sh.third_reset)
    else $error("third slope reset while disabled");

  a_col_direction: assert property (@(posedge core_clk) disable iff (rst)
    (st.fsm == S_READ && seq_tick && seq_rst_n && col_flip
      && st.kcnt != st.regs[OFS_KERNEL_COUNT][7:0]) |=> st.ro.col == 8'($past(st.ro.col) - 8'h01))
    else $error("column does not step right to left");

  a_frame_valid_read: assert property (@(posedge core_clk) disable iff (rst)
    st.ro.frame_valid |-> st.fsm == S_READ)
    else $error("frame valid outside readout");

  a_spi_load: assert property (@(posedge core_clk) disable iff (rst)
    (spi_enable && !st.spi_en_q) |=> st.regs[$past(st.shift[15:12])]
      == ($past(st.shift[11:0]) & REG_MASK[$past(st.shift[15:12])]))
    else $error("serial word not loaded on strobe");

  a_amp_follows: assert property (@(posedge core_clk) disable iff (rst)
    ##1 st.an.amp_on == $past(seqc[SEQ_AMP_OUT]))
    else $error("amplifier enable does not follow its bit");

  c_frame_read: cover property (@(posedge core_clk) disable iff (rst) $fell(st.ro.frame_valid));
  c_ndr_frame: cover property (@(posedge core_clk) disable iff (rst) st.ndr_done && st.fsm == S_READ);
  c_slave_transfer: cover property (@(posedge core_clk) disable iff (rst) !master && st.sh.frame_transfer);
  c_second_slope: cover property (@(posedge core_clk) disable iff (rst) st.sh.second_reset && master);

endmodule : image_sensor_sequencer_config

`default_nettype wire

//--- verif/serial_ctrl_model.sv
// camera controller model driving the three-wire serial interface
`timescale 1ns/1ps
`default_nettype none

module serial_ctrl_model (
  input wire logic core_clk,
  input wire logic frame_valid,
  output logic spi_clk,
  output logic spi_data,
  output logic spi_enable
);
  // ==========================================================================
  // idle levels
  initial begin
    spi_clk = 1'b0;
    spi_data = 1'b0;
    spi_enable = 1'b0;
  end

  // ==========================================================================
  // one word: four address bits then twelve data bits, msb first
  task automatic send(input logic [3:0] addr, input logic [11:0] data, output bit late);
    logic [15:0] w;
    int n;
    w = {addr, data};
    n = 0;
    late = 1'b0;
    while (frame_valid !== 1'b0 && n < 50000) begin
      @(posedge core_clk);
      n++;
    end
    if (frame_valid !== 1'b0) begin
      late = 1'b1;
      return;
    end
    for (int i = 15; i >= 0; i--) begin
      @(posedge core_clk);
      spi_data <= w[i];
      spi_clk <= 1'b0;
      @(posedge core_clk);
      @(posedge core_clk);
      spi_clk <= 1'b1;
      @(posedge core_clk);
    end
    @(posedge core_clk);
    spi_clk <= 1'b0;
    spi_data <= ~w[0]; // released line shows the inverse of the last bit
    spi_enable <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    spi_enable <= 1'b0;
  endtask : send
endmodule : serial_ctrl_model

`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the sensor configuration bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sensor_cfg_pkg::*;
  // ==========================================================================
  // clock, reset, design and controller
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic seq_rst_n = 1'b0;
  logic [2:0] int_time_in = 3'h0;
  logic spi_clk, spi_data, spi_enable;
  int_pins_t int_time;
  shutter_t shutter;
  readout_t readout;
  analog_t analog;
  logic [15:0][11:0] reg_image;
  always #2.5 core_clk = ~core_clk;
  serial_ctrl_model serial_ctrl_model_i (.core_clk(core_clk), .frame_valid(readout.frame_valid),
    .spi_clk(spi_clk), .spi_data(spi_data), .spi_enable(spi_enable));
  image_sensor_sequencer_config image_sensor_sequencer_config_i (.core_clk(core_clk), .rst(rst),
    .spi_clk(spi_clk), .spi_data(spi_data), .spi_enable(spi_enable), .seq_rst_n(seq_rst_n),
    .int_time_in(int_time_in), .int_time(int_time), .shutter(shutter), .readout(readout),
    .analog(analog), .reg_image(reg_image));

  // ==========================================================================
  // register model and observation counters
  logic [11:0] rv [16] = '{12'h029, 12'h000, 12'h000, 12'h0a0, 12'h002, 12'h000, 12'h000, 12'h1e1,
    12'h04a, 12'h06b, 12'h055, 12'h0f0, 12'h7b0, 12'hadf, 12'h6db, 12'h0db};
  int wid [16] = '{11, 8, 9, 8, 12, 12, 12, 12, 8, 8, 8, 12, 12, 12, 12, 9};
  logic [11:0] mdl [16];
  logic [31:0] lfsr;
  logic [10:0] cfg;
  int err_total, num_checks, n_pr, n_s2, n_s3, n_cal, n_ft, fv_bad, t_fv, t_c1, t_pr, t_ft;
  int pin_bad, int_hi;
  int row0, col0, row1, col1, ok;
  int tg [4];
  logic pr_q, fv_q;
  logic [8:0] rw_q;
  logic [7:0] cl_q;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  always @(posedge core_clk) begin
    if (shutter.pix_reset === 1'b1 && pr_q !== 1'b1) t_pr = 0;
    else t_pr++;
    n_pr += (shutter.pix_reset === 1'b1 && pr_q !== 1'b1);
    n_s2 += (shutter.second_reset === 1'b1);
    n_s3 += (shutter.third_reset === 1'b1);
    n_cal += (shutter.calib_pulse === 1'b1);
    if (shutter.frame_transfer === 1'b1) begin
      n_ft++;
      t_ft = t_pr;
      fv_bad += (readout.frame_valid !== 1'b0);
    end
    if (readout.frame_valid === 1'b1 && fv_q !== 1'b1) begin
      row0 = readout.row;
      col0 = readout.col;
      t_fv = 0;
      col1 = -1;
      row1 = -1;
    end else if (readout.frame_valid === 1'b1) begin
      t_fv++;
      if (col1 < 0 && readout.col !== cl_q) begin
        col1 = readout.col;
        t_c1 = t_fv;
      end
      if (row1 < 0 && readout.row !== rw_q) row1 = readout.row;
    end
    pin_bad += (readout.line_valid !== readout.frame_valid);
    pin_bad += (int_time.out[2:1] !== {shutter.third_reset, shutter.second_reset});
    pin_bad += (int_time.out[0] === 1'b1 && shutter.pix_reset === 1'b1);
    int_hi += (int_time.out[0] === 1'b1);
    pr_q = shutter.pix_reset;
    fv_q = readout.frame_valid;
    rw_q = readout.row;
    cl_q = readout.col;
  end

  // ==========================================================================
  // shared tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic chk_reg(input logic [3:0] a);
    num_checks++;
    if (reg_image[a] !== mdl[a]) begin
      err_total++;
      $display("CHECK FAILED %0t register %0h got %h expected %h", $time, a, reg_image[a], mdl[a]);
    end
  endtask : chk_reg

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    bit late;
    serial_ctrl_model_i.send(a, d, late);
    if (late) begin
      err_total++;
      $display("CHECK FAILED %0t serial wait ran out", $time);
      finish_test();
    end
    mdl[a] = d & 12'((13'h1 << wid[a]) - 13'h1);
    repeat (2) @(negedge core_clk);
  endtask : wr

  task automatic seq_hold(input logic v);
    @(posedge core_clk);
    seq_rst_n <= v;
    @(negedge core_clk);
    {n_pr, n_s2, n_s3, n_cal, n_ft, fv_bad, pin_bad, int_hi} = '0;
  endtask : seq_hold

  task automatic wait_frame;
    int n;
    n = 0;
    while (readout.frame_valid !== 1'b1 && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    while (readout.frame_valid !== 1'b0 && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 40000) begin
      err_total++;
      $display("CHECK FAILED %0t frame wait ran out", $time);
      finish_test();
    end
  endtask : wait_frame

  // ==========================================================================
  // main sequence
  initial begin
    lfsr = 32'h00012997;
    for (int a = 0; a < 16; a++) mdl[a] = rv[a];
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(negedge core_clk);
    for (int a = 0; a < 16; a++) chk_reg(4'(a));
    chk_val(12'(readout.frame_valid), 12'h000, "idle frame valid");
    $display("test reset_values done");
    for (int a = 0; a < 16; a++) begin
      lfsr = lfsr_next(lfsr);
      wr(4'(a), lfsr[11:0]);
      chk_reg(4'(a));
    end
    chk_val(12'(analog.half_gain_on), 12'(!mdl[12][5]), "half gain");
    $display("test random_writes done");
    wr(OFS_KERNEL_COUNT, 12'h002);
    wr(OFS_COLUMN_ORIGIN, 12'h003);
    wr(OFS_RESET_PULSE_SPAN, 12'h002);
    wr(OFS_SECOND_SLOPE_POSITION, 12'h002);
    wr(OFS_THIRD_SLOPE_POSITION, 12'h003);
    wr(OFS_TRANSFER_POSITION, 12'h005);
    for (int k = 0; k < 4; k++) begin
      seq_hold(1'b0);
      cfg = {1'b0, k[1], k[1] ^ k[0], k[1], k[0], k[0], ~k[0], 2'(k), k[0], 1'b1};
      wr(OFS_ROW_ORIGIN, cfg[9] ? 12'h00a : 12'h1d0);
      wr(OFS_SEQUENCER_CONTROL, {1'b0, cfg});
      chk_val(12'(analog.amp_on), 12'(cfg[4]), "amp on");
      chk_val(12'(int_time.oe_n), 12'h000, "master pins");
      seq_hold(1'b1);
      wait_frame();
      tg[k] = t_ft;
      chk_val(12'(row0), cfg[9] ? 12'h00a : 12'h1d0, "first row");
      chk_val(12'(col0), 12'h006, "first kernel");
      chk_val(12'(col1), cfg[8] ? 12'h005 : 12'h007, "column step");
      chk_val(12'(row1), 12'(cfg[9] ? 10 - (cfg[1] ? 2 : 1) : 464 + (cfg[1] ? 2 : 1)), "row step");
      chk_val(12'(t_c1), 12'h004, "kernel interval");
      chk_val(12'(n_s2), 12'(cfg[6]), "second slope");
      chk_val(12'(n_s3), 12'(cfg[7]), "third slope");
      chk_val(cfg[5] ? 12'(n_cal > 1) : 12'(n_cal), 12'h001, "calibration");
      chk_val(12'(n_pr), 12'h001, "pixel reset");
      chk_val(12'(fv_bad), 12'h000, "transfer in overhead");
      chk_val(12'(pin_bad), 12'h000, "pin mirror");
      chk_val(12'(int_hi > 0), 12'h001, "integration pin");
    end
    for (int k = 1; k < 4; k++) begin
      ok = (tg[k] * 8 > (tg[0] << k) * 7) && (tg[k] * 8 < (tg[0] << k) * 9);
      chk_val(12'(ok), 12'h001, "granularity");
    end
    $display("test master_frames done");
    seq_hold(1'b0);
    wr(OFS_SEQUENCER_CONTROL, 12'h429);
    seq_hold(1'b1);
    wait_frame();
    chk_val(12'(n_pr), 12'h001, "first read reset");
    {n_pr, n_ft} = '0;
    wait_frame();
    chk_val(12'(n_pr), 12'h000, "repeat read reset");
    seq_hold(1'b0);
    wr(OFS_SEQUENCER_CONTROL, 12'h029);
    $display("test nondestructive done");
    lfsr = lfsr_next(lfsr);
    wr(OFS_SEQUENCER_CONTROL, {1'b0, lfsr[10:8], 8'h28});
    chk_val(12'(int_time.oe_n), 12'h007, "slave pins");
    seq_hold(1'b1);
    @(posedge core_clk);
    int_time_in <= 3'h1;
    repeat (200) @(posedge core_clk);
    int_time_in <= 3'h0;
    wait_frame();
    chk_val(12'(n_ft), 12'h001, "slave transfer");
    $display("test slave_frame done");
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
